//--- fspu_pkg.sv
// Notes on behaviour
// - erase: pattern X0000011, store within four cycles
// - erase ignores data pair, non-page pointer bits
// - load: pattern 00000001, data to word slot
// - buffer clears on write done, reenable, reset
// - software loads each slot once per erase
// - eeprom write keeps loaded buffer words
// - write: pattern X0000101, store within four cycles
// - software zeroes non-page pointer bits on write
// - low-section target runs; high-section target stalls
// - target page latched when operation starts
// - pointer is low, high and extension bytes
// - load-program reads bytes; bit zero picks byte
// - interrupt asserted while enabled and enable clear
// - section busy flag set while section blocked
// - busy stays until reenable bit written
// - lock: pattern X0001001; zero data bits 5:0 program
// - lock programming neither blocks reads nor stalls
// - eeprom write refuses commands and fuse readback
// - pointer 0x0001 armed load-program returns lock bits
// - arming clears on readback or window expiry
// - pointers 0,3,2 return fuse low, high, extended
// - programmed bits read zero, unprogrammed one
// - erase, write, lock last 3.7 to 4.5 ms
package fspu_pkg;
  // clock and programming time
  localparam int CLK_PERIOD_NS   = 40;
  localparam int PROG_MIN_NS     = 3_700_000;
  localparam int PROG_MAX_NS     = 4_500_000;
  localparam int PROG_MIN_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_PERIOD_NS;
  localparam int TMR_W           = 17;
  // command windows in cycles
  localparam logic [2:0] SPM_WINDOW  = 3'h4;
  localparam logic [2:0] LPM_WINDOW  = 3'h3;
  localparam logic [2:0] LPM_MIN_WIN = SPM_WINDOW - LPM_WINDOW;
  // control/status bit positions
  localparam int CB_ENABLE   = 0;
  localparam int CB_ERASE    = 1;
  localparam int CB_WRITE    = 2;
  localparam int CB_LOCK_SEL = 3;
  localparam int CB_REENABLE = 4;
  localparam int CB_RWW_BUSY = 6;
  localparam int CB_INT_EN   = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // command codes as {lock_sel, write, erase}
  localparam logic [2:0] CMD_LOAD  = 3'h0;
  localparam logic [2:0] CMD_ERASE = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_LOCK  = 3'h4;
  // pointer layout
  localparam int PTR_W      = 24;
  localparam int BYTE_SEL   = 0;
  localparam int WORD_LSB   = 1;
  localparam int WORD_W     = 7;
  localparam int PAGE_LSB   = 8;
  localparam int PAGE_W     = 10;
  localparam int PAGE_WORDS = 128;
  localparam logic [PAGE_W-1:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 10'h3E0;
  // readback addresses
  localparam logic [PTR_W-1:0] RB_FUSE_LOW  = 24'h00_0000;
  localparam logic [PTR_W-1:0] RB_LOCK      = 24'h00_0001;
  localparam logic [PTR_W-1:0] RB_FUSE_EXT  = 24'h00_0002;
  localparam logic [PTR_W-1:0] RB_FUSE_HIGH = 24'h00_0003;
  // reset values
  localparam logic [7:0]  LOCK_RESET = 8'hFF;
  localparam logic [15:0] BUF_ERASED = 16'hFFFF;
  localparam int LOCK_FIELD_W = 6;
  // host register offsets
  localparam logic [3:0] HR_CTRL    = 4'h0;
  localparam logic [3:0] HR_PTR_LO  = 4'h1;
  localparam logic [3:0] HR_PTR_HI  = 4'h2;
  localparam logic [3:0] HR_PTR_EXT = 4'h3;
  localparam logic [3:0] HR_DATA_LO = 4'h4;
  localparam logic [3:0] HR_DATA_HI = 4'h5;
  localparam logic [3:0] HR_ISSUE   = 4'h6;
  localparam logic [3:0] HR_RESULT  = 4'h7;
  localparam logic [3:0] HR_STATE   = 4'h8;
  localparam int IS_SPM = 0;
  localparam int IS_LPM = 1;
  // operation in flight
  typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE, OP_LOCK} fspu_op_t;
endpackage

//--- fspu_if.sv
`timescale 1ns/1ns
interface fspu_if;
  import fspu_pkg::*;
  logic              ctrl_wr;      // control register write pulse
  logic [7:0]        ctrl_wdata;   // control register write value
  logic [7:0]        ctrl_status;  // control register read value
  logic [PTR_W-1:0]  pointer;      // extension, high, low pointer
  logic [15:0]       data_pair;    // data operand pair
  logic              spm_strobe;   // store-program instruction
  logic              lpm_strobe;   // load-program instruction
  logic [7:0]        lpm_data;     // byte returned
  logic              lpm_valid;    // lpm_data valid pulse
  logic              cpu_stall;    // core halted
  logic              irq;          // completion interrupt level
  logic              eeprom_busy;  // eeprom write in progress
  modport dev (input ctrl_wr, ctrl_wdata, pointer, data_pair, spm_strobe, lpm_strobe,
               eeprom_busy, output ctrl_status, lpm_data, lpm_valid, cpu_stall, irq);
  modport host (output ctrl_wr, ctrl_wdata, pointer, data_pair, spm_strobe, lpm_strobe,
                eeprom_busy, input ctrl_status, lpm_data, lpm_valid, cpu_stall, irq);
endinterface

//--- fspu_timer.sv
`timescale 1ns/1ns
module fspu_timer (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      start,
  input  wire logic [fspu_pkg::TMR_W-1:0] cycles,
  output logic                           done
);
  import fspu_pkg::*;
  typedef struct packed {
    logic [TMR_W-1:0] cnt;   // cycles left
    logic             done;  // end pulse
  } fspu_tmr_t;
  fspu_tmr_t s;
  fspu_tmr_t next_s;

  // countdown, done pulse on last count
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start) begin
      next_s.cnt = cycles;
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 1'b1;
      if (s.cnt == {{(TMR_W-1){1'b0}}, 1'b1}) begin
        next_s.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
endmodule

//--- fspu_device.sv
`timescale 1ns/1ns
module fspu_device #(
  parameter int unsigned PROG_CYCLES = fspu_pkg::PROG_MIN_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  fspu_if.dev                                bus,
  input  wire logic [7:0]                    fuse_low,
  input  wire logic [7:0]                    fuse_high,
  input  wire logic [7:0]                    fuse_ext,
  input  wire logic [15:0]                   flash_word,
  input  wire logic [fspu_pkg::WORD_W-1:0]   buf_idx,
  output logic [15:0]                        buf_word,
  output logic                               op_start,
  output fspu_pkg::fspu_op_t                 op_kind,
  output logic [fspu_pkg::PAGE_W-1:0]        op_page,
  output logic                               rww_blocked,
  output logic [7:0]                         lock_bits
);
  import fspu_pkg::*;

  typedef struct packed {
    logic                              int_en;    // interrupt enable
    logic                              en;        // self-program enable
    logic                              erase;     // erase command bit
    logic                              write;     // write command bit
    logic                              lock_sel;  // lock select bit
    logic [2:0]                        win;       // command window left
    logic                              rww_busy;  // section busy flag
    logic                              stall;     // core halted
    fspu_op_t                          op;        // operation in flight
    logic [PAGE_W-1:0]                 page;      // latched target page
    logic [7:0]                        lock;      // lock bits
    logic [PAGE_WORDS-1:0][15:0]       bufw;      // temporary page buffer
    logic [7:0]                        lpm_data;  // load-program result
    logic                              lpm_valid; // result pulse
    logic [7:0]                        status;    // control readback
    logic                              irq;       // interrupt level
    logic                              tmr_start; // timer kick
    logic                              op_start;  // operation start pulse
    logic [15:0]                       buf_word;  // buffer readout
  } fspu_dev_t;

  fspu_dev_t        s;
  fspu_dev_t        next_s;
  logic             tmr_done;  // operation time elapsed
  logic [2:0]       cmd;       // armed command code
  logic [PAGE_W-1:0] tgt_page; // page field of pointer
  logic             rb_armed;  // readback may answer
  logic             spm_take;  // store accepted this cycle

  // fixed programming time, shortened in simulation
  // op stays busy PROG_CYCLES + 2 cycles from the store
  fspu_timer u_timer (
    .clk    (clk),
    .rst    (rst),
    .start  (s.tmr_start),
    .cycles (TMR_W'(PROG_CYCLES)),
    .done   (tmr_done)
  );

  // next state
  always_comb begin
    // hold state; pulses default low
    next_s = s;
    next_s.op_start = 1'b0;
    next_s.lpm_valid = 1'b0;
    next_s.tmr_start = 1'b0;
    // command code from the armed bits
    cmd = {s.lock_sel, s.write, s.erase};
    // only the page field counts; data pair and word bits unused
    tgt_page = bus.pointer[PAGE_LSB +: PAGE_W];
    // readback only in the first three window cycles
    rb_armed = s.en && s.lock_sel && (s.win > LPM_MIN_WIN) && !bus.eeprom_busy;
    // store taken: idle, armed, inside the window
    spm_take = (s.op == OP_IDLE) && (s.win != '0) && bus.spm_strobe && s.en;
    if (s.op != OP_IDLE) begin
      // operation running; enable held until done
      if (tmr_done) begin
        next_s.op = OP_IDLE;
        next_s.en = 1'b0;
        next_s.erase = 1'b0;
        next_s.write = 1'b0;
        next_s.lock_sel = 1'b0;
        next_s.stall = 1'b0;
        if (s.op == OP_WRITE) begin
          next_s.bufw = {PAGE_WORDS{BUF_ERASED}};
        end
      end
    end else if (spm_take) begin
      // store-program inside the window
      next_s.win = '0;
      case (cmd)
        CMD_LOAD: begin
          // data pair into the word slot
          next_s.bufw[bus.pointer[WORD_LSB +: WORD_W]] = bus.data_pair;
          next_s.en = 1'b0;
        end
        CMD_ERASE, CMD_WRITE: begin
          // latch page, block section, maybe halt core
          next_s.page = tgt_page;
          next_s.op = (cmd == CMD_ERASE) ? OP_ERASE : OP_WRITE;
          next_s.op_start = 1'b1;
          next_s.tmr_start = 1'b1;
          next_s.rww_busy = 1'b1;
          next_s.stall = (tgt_page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
        end
        CMD_LOCK: begin
          // zero data bits 5:0 program lock bits 5:0, pointer ignored
          next_s.lock = s.lock & {2'b11, bus.data_pair[LOCK_FIELD_W-1:0]};
          next_s.op = OP_LOCK;
          next_s.op_start = 1'b1;
          next_s.tmr_start = 1'b1;
        end
        default: begin
          // unknown pattern drops the arming
          next_s.en = 1'b0;
          next_s.erase = 1'b0;
          next_s.write = 1'b0;
          next_s.lock_sel = 1'b0;
        end
      endcase
    end else if (s.win != '0) begin
      // window runs down, arming dropped at its end
      next_s.win = s.win - 3'h1;
      if (s.win == 3'h1) begin
        next_s.en = 1'b0;
        next_s.erase = 1'b0;
        next_s.write = 1'b0;
        next_s.lock_sel = 1'b0;
      end
    end
    // load-program answer, byte wide
    // pointer bit zero picks the byte of the word
    if (bus.lpm_strobe) begin
      next_s.lpm_valid = 1'b1;
      next_s.lpm_data = bus.pointer[BYTE_SEL] ? flash_word[15:8] : flash_word[7:0];
      if (rb_armed && (s.op == OP_IDLE)) begin
        next_s.en = 1'b0;
        next_s.lock_sel = 1'b0;
        next_s.win = '0;
        case (bus.pointer)
          RB_FUSE_LOW:  next_s.lpm_data = fuse_low;
          RB_LOCK:      next_s.lpm_data = s.lock;
          RB_FUSE_EXT:  next_s.lpm_data = fuse_ext;
          RB_FUSE_HIGH: next_s.lpm_data = fuse_high;
          default:      next_s.lpm_data = next_s.lpm_data;
        endcase
      end
    end
    // control write, refused while busy or eeprom writes;
    // a store taken in the same cycle wins, so a reenable cannot undo it
    // eeprom activity blocks commands but never touches the buffer
    if (bus.ctrl_wr && (s.op == OP_IDLE) && !bus.eeprom_busy && !spm_take) begin
      next_s.int_en = bus.ctrl_wdata[CB_INT_EN];
      if (bus.ctrl_wdata[CB_REENABLE]) begin
        // reenable: free section, empty buffer
        next_s.rww_busy = 1'b0;
        next_s.bufw = {PAGE_WORDS{BUF_ERASED}};
        next_s.en = 1'b0;
        next_s.win = '0;
      end else begin
        // arm a command
        next_s.en = bus.ctrl_wdata[CB_ENABLE];
        next_s.erase = bus.ctrl_wdata[CB_ERASE];
        next_s.write = bus.ctrl_wdata[CB_WRITE];
        next_s.lock_sel = bus.ctrl_wdata[CB_LOCK_SEL];
        next_s.win = bus.ctrl_wdata[CB_ENABLE] ? SPM_WINDOW : 3'h0;
      end
    end
    // derived outputs from the coming state
    // irq registered together with the status it reflects
    next_s.irq = next_s.int_en && !next_s.en;
    // status readback in control bit order
    next_s.status = {next_s.int_en, next_s.rww_busy, 1'b0, 1'b0,
                     next_s.lock_sel, next_s.write, next_s.erase, next_s.en};
    // buffer readout sees same-edge loads
    next_s.buf_word = next_s.bufw[buf_idx];
  end

  // state register; reset empties buffer
  always_ff @(posedge clk) begin
    if (rst) begin
      // all state cleared, then the non-zero reset values
      s <= '0;
      s.op <= OP_IDLE;
      s.lock <= LOCK_RESET;
      s.bufw <= {PAGE_WORDS{BUF_ERASED}};
      s.status <= CTRL_RESET;
      s.buf_word <= BUF_ERASED;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state
  assign bus.ctrl_status = s.status;
  assign bus.lpm_data    = s.lpm_data;
  assign bus.lpm_valid   = s.lpm_valid;
  assign bus.cpu_stall   = s.stall;
  assign bus.irq         = s.irq;
  assign buf_word        = s.buf_word;
  assign op_start        = s.op_start;
  assign op_kind         = s.op;
  assign op_page         = s.page;
  assign rww_blocked     = s.rww_busy;
  assign lock_bits       = s.lock;
endmodule

//--- fspu_host.sv
`timescale 1ns/1ns
module fspu_host (
  input  wire logic       clk,
  input  wire logic       rst,
  fspu_if.host            bus,
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic [7:0]      sw_rdata,
  input  wire logic       eeprom_busy_in,
  output logic            irq_out
);
  import fspu_pkg::*;

  typedef struct packed {
    logic                ctrl_wr;   // control write pulse
    logic [7:0]          ctrl_wdata;
    logic [PTR_W-1:0]    ptr;       // pointer bytes
    logic [15:0]         data;      // data operand pair
    logic                spm;       // store strobe
    logic                lpm;       // load strobe
    logic                pend_spm;  // held during stall
    logic                pend_lpm;
    logic [7:0]          result;    // last load byte
    logic                res_valid; // sticky result flag
    logic [7:0]          rdata;     // software read data
    logic                irq;
    logic                ee_busy;
  } fspu_host_t;

  fspu_host_t s;
  fspu_host_t next_s;

  // next state
  always_comb begin
    next_s = s;
    next_s.ctrl_wr = 1'b0;
    next_s.spm = 1'b0;
    next_s.lpm = 1'b0;
    next_s.rdata = 8'h00;
    next_s.irq = bus.irq;
    next_s.ee_busy = eeprom_busy_in;
    // software writes
    if (sw_wr) begin
      case (sw_addr)
        HR_CTRL: begin
          next_s.ctrl_wr = 1'b1;
          next_s.ctrl_wdata = sw_wdata;
        end
        HR_PTR_LO:  next_s.ptr[7:0] = sw_wdata;
        HR_PTR_HI:  next_s.ptr[15:8] = sw_wdata;
        HR_PTR_EXT: next_s.ptr[23:16] = sw_wdata;
        HR_DATA_LO: next_s.data[7:0] = sw_wdata;
        HR_DATA_HI: next_s.data[15:8] = sw_wdata;
        HR_ISSUE: begin
          next_s.pend_spm = sw_wdata[IS_SPM];
          next_s.pend_lpm = sw_wdata[IS_LPM];
        end
        default: next_s.ctrl_wr = 1'b0;
      endcase
    end
    // a halted core issues nothing
    if (!bus.cpu_stall) begin
      if (next_s.pend_spm) begin
        next_s.spm = 1'b1;
        next_s.pend_spm = 1'b0;
      end else if (next_s.pend_lpm) begin
        next_s.lpm = 1'b1;
        next_s.pend_lpm = 1'b0;
      end
    end
    // software reads; result read clears flag
    if (sw_rd) begin
      case (sw_addr)
        HR_CTRL:    next_s.rdata = bus.ctrl_status;
        HR_PTR_LO:  next_s.rdata = s.ptr[7:0];
        HR_PTR_HI:  next_s.rdata = s.ptr[15:8];
        HR_PTR_EXT: next_s.rdata = s.ptr[23:16];
        HR_DATA_LO: next_s.rdata = s.data[7:0];
        HR_DATA_HI: next_s.rdata = s.data[15:8];
        HR_RESULT: begin
          next_s.rdata = s.result;
          next_s.res_valid = 1'b0;
        end
        HR_STATE: next_s.rdata = {5'h00, s.irq, bus.cpu_stall, s.res_valid};
        default:  next_s.rdata = 8'h00;
      endcase
    end
    // capture load byte; set wins over clear
    if (bus.lpm_valid) begin
      next_s.result = bus.lpm_data;
      next_s.res_valid = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state
  assign bus.ctrl_wr     = s.ctrl_wr;
  assign bus.ctrl_wdata  = s.ctrl_wdata;
  assign bus.pointer     = s.ptr;
  assign bus.data_pair   = s.data;
  assign bus.spm_strobe  = s.spm;
  assign bus.lpm_strobe  = s.lpm;
  assign bus.eeprom_busy = s.ee_busy;
  assign sw_rdata        = s.rdata;
  assign irq_out         = s.irq;
endmodule

//--- fspu_chk.sv
`timescale 1ns/1ns
module fspu_chk
  import fspu_pkg::*;
#(
  parameter int PROG_CYCLES = 10
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              ctrl_wr,
  input wire logic [7:0]        ctrl_wdata,
  input wire logic [7:0]        ctrl_status,
  input wire logic [PTR_W-1:0]  pointer,
  input wire logic              spm_strobe,
  input wire logic              lpm_strobe,
  input wire logic              lpm_valid,
  input wire logic              cpu_stall,
  input wire logic              irq,
  input wire logic              eeprom_busy
);
  // longest op seen from the busy rise, with margin
  localparam int OP_MAX = PROG_CYCLES + 4;
  logic en;    // enable bit as reported
  logic busy;  // section busy flag as reported
  assign en   = ctrl_status[CB_ENABLE];
  assign busy = ctrl_status[CB_RWW_BUSY];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_lpm_answer_once: assert property (lpm_valid == $past(lpm_strobe))
    else $error("load answer not one cycle after strobe");
  chk_irq_tracks_enable: assert property (irq == (ctrl_status[CB_INT_EN] & ~en))
    else $error("irq does not follow enable state");
  chk_eeprom_refuses: assert property ((ctrl_wr && eeprom_busy && !en) |=> !en)
    else $error("command armed during eeprom write");
  chk_arm_expires: assert property ((ctrl_wr && ctrl_wdata[4:0] == 5'h01 && !en) |-> ##[1:5] !en)
    else $error("arming did not expire");
  chk_busy_holds: assert property ((busy && !(ctrl_wr && ctrl_wdata[CB_REENABLE])) |=> busy)
    else $error("busy dropped without reenable");
  chk_reenable_clears: assert property ((ctrl_wr && ctrl_wdata[CB_REENABLE] && !en && !eeprom_busy)
    |=> !busy && !en)
    else $error("reenable did not clear busy");
  chk_busy_on_prog: assert property ((spm_strobe && en && (ctrl_status[1] ^ ctrl_status[2])
    && !ctrl_status[3]) |-> ##[1:2] busy)
    else $error("busy not set by erase or write");
  chk_stall_in_op: assert property (cpu_stall |-> en)
    else $error("stall outside an operation");
  chk_low_page_runs: assert property ((spm_strobe && en && ctrl_status[2:1] != 2'b00
    && pointer[17:8] < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE) |=> !cpu_stall[*4])
    else $error("stall for low section target");
  chk_lock_no_stall: assert property ((spm_strobe && en && ctrl_status[3:1] == 3'b100)
    |=> (!cpu_stall && $stable(busy))[*4])
    else $error("lock programming blocked the core");
  chk_op_duration: assert property ($rose(busy) |-> en[*8] ##[1:OP_MAX] !en)
    else $error("operation length wrong");
  // main scenarios reached
  cover property (lpm_valid);
  cover property (cpu_stall);
  cover property ($fell(busy));
endmodule

//--- fspu_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module fspu_bench;
  import fspu_pkg::*;
  localparam int          PROG   = 10;  // shortened programming time
  localparam logic [7:0]  F_LO   = 8'h62;
  localparam logic [7:0]  F_HI   = 8'h99;
  localparam logic [7:0]  F_EX   = 8'hFD;
  localparam logic [7:0]  RB [6] = '{8'h62, 8'hFF, 8'hFD, 8'h99, 8'h04, 8'hFA};
  logic        clk;
  logic        rst;
  logic [3:0]  sw_addr;
  logic [7:0]  sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [7:0]  sw_rdata;
  logic        ee_busy;
  logic        irq_out;
  logic [6:0]  buf_idx;
  logic [15:0] buf_word;
  logic [15:0] flash_word;
  logic        op_start;
  fspu_op_t    op_kind;
  fspu_op_t    st_kind;
  logic [9:0]  op_page;
  logic [9:0]  st_page;
  logic        rww_blocked;
  logic [7:0]  lock_bits;
  int          n_mismatch;
  int          checks_done;
  fspu_if i_fspu_if ();
  // array content: low byte is pointer, high byte its inverse
  assign flash_word = {~i_fspu_if.pointer[7:0], i_fspu_if.pointer[7:0]};
  fspu_device #(.PROG_CYCLES(PROG)) i_fspu_device (
    .clk(clk), .rst(rst), .bus(i_fspu_if), .fuse_low(F_LO), .fuse_high(F_HI),
    .fuse_ext(F_EX), .flash_word(flash_word), .buf_idx(buf_idx), .buf_word(buf_word),
    .op_start(op_start), .op_kind(op_kind), .op_page(op_page),
    .rww_blocked(rww_blocked), .lock_bits(lock_bits));
  fspu_host i_fspu_host (
    .clk(clk), .rst(rst), .bus(i_fspu_if), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .eeprom_busy_in(ee_busy),
    .irq_out(irq_out));
  fspu_chk #(.PROG_CYCLES(PROG)) i_fspu_chk (
    .clk(clk), .rst(rst), .ctrl_wr(i_fspu_if.ctrl_wr), .ctrl_wdata(i_fspu_if.ctrl_wdata),
    .ctrl_status(i_fspu_if.ctrl_status), .pointer(i_fspu_if.pointer),
    .spm_strobe(i_fspu_if.spm_strobe), .lpm_strobe(i_fspu_if.lpm_strobe),
    .lpm_valid(i_fspu_if.lpm_valid), .cpu_stall(i_fspu_if.cpu_stall),
    .irq(i_fspu_if.irq), .eeprom_busy(i_fspu_if.eeprom_busy));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // capture kind and page at each operation start
  always @(posedge clk) begin
    if (op_start === 1'b1) begin
      st_kind <= op_kind;
      st_page <= op_page;
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  // read, data taken in the cycle after the strobe
  task automatic xrd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    `CHK(sw_rdata, e)
  endtask
  task automatic ptr(input logic [23:0] p);
    wr(HR_PTR_LO, p[7:0]);
    wr(HR_PTR_HI, p[15:8]);
    wr(HR_PTR_EXT, p[23:16]);
  endtask
  // arm a command, then issue a store
  task automatic spm(input logic [7:0] cmd);
    wr(HR_CTRL, cmd);
    wr(HR_ISSUE, 8'h01);
  endtask
  // armed readback after a gap of idle cycles
  task automatic lpm(input logic [23:0] p, input int gap, input logic [7:0] e);
    ptr(p);
    wr(HR_CTRL, 8'h09);
    repeat (gap) @(posedge clk);
    wr(HR_ISSUE, 8'h02);
    repeat (3) @(posedge clk);
    xrd(HR_RESULT, e);
  endtask
  task automatic load(input logic [6:0] s, input logic [15:0] w);
    ptr({16'h0000, s, 1'b0});
    wr(HR_DATA_LO, w[7:0]);
    wr(HR_DATA_HI, w[15:8]);
    spm(8'h01);
  endtask
  task automatic buf_chk(input logic [6:0] s, input logic [15:0] e);
    @(posedge clk);
    buf_idx <= s;
    @(posedge clk);
    @(negedge clk);
    `CHK(buf_word, e)
  endtask
  // poll the enable bit with a bound
  task automatic wait_done();
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (i_fspu_if.ctrl_status[CB_ENABLE] === 1'b0) break;
    end
    if (i == 60) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  initial begin
    rst = 1'b1; sw_addr = 4'h0; sw_wdata = 8'h00; sw_wr = 1'b0; sw_rd = 1'b0;
    ee_busy = 1'b0; buf_idx = 7'h00; n_mismatch = 0; checks_done = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // reset state and unmapped read
    xrd(HR_CTRL, 8'h00);
    xrd(4'hF, 8'h00);
    `CHK(lock_bits, 8'hFF)
    buf_chk(7'h00, 16'hFFFF);
    // fuse, lock and flash byte readback
    for (int p = 0; p < 6; p++) lpm(p, 0, RB[p]);
    lpm(24'h00_0001, 6, 8'hFE);
    xrd(HR_CTRL, 8'h00);
    // page loads, one refused during eeprom write
    load(7'h00, 16'h1234);
    load(7'h7F, 16'hABCD);
    @(posedge clk) ee_busy <= 1'b1;
    load(7'h05, 16'h5555);
    lpm(24'h00_0001, 0, 8'hFE);
    @(posedge clk) ee_busy <= 1'b0;
    buf_chk(7'h00, 16'h1234);
    buf_chk(7'h7F, 16'hABCD);
    buf_chk(7'h05, 16'hFFFF);
    // erase low page, pointer moved during the op
    ptr(24'h00_03FF);
    spm(8'h83);
    ptr(24'h00_0500);
    xrd(HR_CTRL, 8'hC3);
    `CHK(rww_blocked, 1'b1)
    wait_done();
    `CHK(st_kind, OP_ERASE)
    `CHK(st_page, 10'h003)
    `CHK(op_page, 10'h003)
    repeat (3) @(posedge clk);
    xrd(HR_CTRL, 8'hC0);
    xrd(HR_STATE, 8'h04);
    `CHK(irq_out, 1'b1)
    wr(HR_CTRL, 8'h91);
    xrd(HR_CTRL, 8'h80);
    buf_chk(7'h00, 16'hFFFF);
    wr(HR_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    xrd(HR_STATE, 8'h00);
    // write to a high section page stalls the core
    load(7'h01, 16'hBEEF);
    ptr(24'h03_E000);
    spm(8'h05);
    repeat (2) @(posedge clk);
    xrd(HR_STATE, 8'h02);
    wait_done();
    `CHK(st_kind, OP_WRITE)
    `CHK(st_page, 10'h3E0)
    repeat (3) @(posedge clk);
    xrd(HR_STATE, 8'h00);
    xrd(HR_CTRL, 8'h40);
    buf_chk(7'h01, 16'hFFFF);
    wr(HR_CTRL, 8'h11);
    // lock bits: no stall, no busy, readback as written
    wr(HR_DATA_LO, 8'hF0);
    ptr(24'h00_0001);
    spm(8'h09);
    repeat (2) @(posedge clk);
    xrd(HR_STATE, 8'h00);
    xrd(HR_CTRL, 8'h09);
    wait_done();
    `CHK(st_kind, OP_LOCK)
    `CHK(lock_bits, 8'hF0)
    lpm(24'h00_0001, 0, 8'hF0);
    // mid-run reset empties the buffer and restores lock bits
    load(7'h02, 16'h1111);
    buf_chk(7'h02, 16'h1111);
    @(posedge clk) rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    buf_chk(7'h02, 16'hFFFF);
    `CHK(lock_bits, 8'hFF)
    xrd(HR_CTRL, 8'h00);
    end_of_test();
  end
endmodule
